// file: gic_regs.sv
// Purpose: Genlock timing control and analog input control registers with their effects.
// Assumes: Sub-address port decoded from the serial control interface, same clock.
// Notes:   Video timing events are one-cycle pulses from the timing core.
`timescale 1ns/1ps
`include "gic_cfg.svh"
module gic_regs
    import gic_pkg::*;
#(
    parameter int H_MISS_LONG = `GIC_H_MISS_LONG,
    parameter int V_MISS_LONG = `GIC_V_MISS_LONG
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    input  wire logic [2:0] out_format_i,
    input  wire logic       field_end_i,
    input  wire logic       field_start_i,
    input  wire logic       active_video_i,
    input  wire logic       active_line_i,
    input  wire logic       pixel_phase_i,
    input  wire logic       line_lock_i,
    input  wire logic       normal_strobe_i,
    input  wire logic       pixel_clock_in_i,
    input  wire logic       hsync_expect_i,
    input  wire logic       hsync_seen_i,
    input  wire logic       vsync_expect_i,
    input  wire logic       vsync_seen_i,
    input  wire logic       sync_loss_i,
    input  wire logic       lock_achieved_i,
    output logic            square_pixel_o,
    output logic            timing_frozen_o,
    output logic            pixel_valid_strobe_o,
    output logic            h_acquire_o,
    output logic            v_acquire_o,
    output logic      [1:0] clock_freq_o,
    output logic      [1:0] gain_mode_o,
    output logic            aa_bypass_o,
    output logic      [1:0] source_sel_o
);
    logic [7:0]     genlock_r;
    logic [7:0]     analog_r;
    logic [1:0]     gain_nxt;
    logic           relock_r;
    gic_frz_state_t frz_r;
    logic           pclk_meta_r;
    logic           pclk_sync_r;
    logic           strobe_nxt;
    logic           wide_fmt;
    logic           narrow_fmt;
    logic [1:0]     gain_fld;
    logic [1:0]     llg_fld;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction

    assign gain_fld   = analog_r[`GIC_GAIN_MSB:`GIC_GAIN_LSB];
    assign llg_fld    = analog_r[`GIC_LLG_MSB:`GIC_LLG_LSB];
    // Formats decode
    assign wide_fmt   = out_format_i == GIC_FMT_YC16 || out_format_i == GIC_FMT_RGB15
                     || out_format_i == GIC_FMT_RGB16;
    assign narrow_fmt = out_format_i == GIC_FMT_YC8 || out_format_i == GIC_FMT_EMB8;

    // The clock frequency field is stored as written; matching the clock is software's duty.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            genlock_r <= `GIC_GENLOCK_RST;
        end else if (wr_en_i && hit(addr_i, `GIC_ADDR_GENLOCK)) begin
            genlock_r <= wdata_i;
        end
    end

    // Sync loss rewrite beats a host write of the same cycle.
    always_comb begin
        gain_nxt = gain_fld;
        if (wr_en_i && hit(addr_i, `GIC_ADDR_ANALOG)) begin
            gain_nxt = wdata_i[`GIC_GAIN_MSB:`GIC_GAIN_LSB];
        end
        if (sync_loss_i && gain_fld != GIC_GAIN_AUTO) begin
            case (llg_fld)
                GIC_LLG_AUTO: gain_nxt = GIC_GAIN_AUTO;
                GIC_LLG_KEEP: gain_nxt = gain_nxt;
                GIC_LLG_RELOCK: begin
                    if (gain_fld == GIC_GAIN_FREEZE) begin
                        gain_nxt = GIC_GAIN_AUTO;
                    end
                end
                default: gain_nxt = gain_nxt;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_r <= `GIC_ANALOG_RST;
        end else begin
            if (wr_en_i && hit(addr_i, `GIC_ADDR_ANALOG)) begin
                analog_r[`GIC_LLG_MSB:`GIC_LLG_LSB] <= wdata_i[`GIC_LLG_MSB:`GIC_LLG_LSB];
                analog_r[`GIC_BIT_AA_BYPASS:0]     <= wdata_i[`GIC_BIT_AA_BYPASS:0];
            end
            analog_r[`GIC_GAIN_MSB:`GIC_GAIN_LSB] <= gain_nxt;
        end
    end

    // Relock mode stays automatic until the lock arrives after a loss.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            relock_r <= 1'b0;
        end else if (sync_loss_i) begin
            relock_r <= 1'b1;
        end else if (lock_achieved_i) begin
            relock_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_mode_o <= GIC_GAIN_AUTO;
        end else if (llg_fld == GIC_LLG_RELOCK && relock_r && gain_fld != GIC_GAIN_AUTO) begin
            gain_mode_o <= GIC_GAIN_AUTO;
        end else begin
            gain_mode_o <= gain_fld;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `GIC_UNMAPPED_DATA;
        end else if (rd_en_i) begin
            if (hit(addr_i, `GIC_ADDR_GENLOCK)) begin
                rdata_o <= genlock_r;
            end else if (hit(addr_i, `GIC_ADDR_ANALOG)) begin
                rdata_o <= analog_r;
            end else begin
                rdata_o <= `GIC_UNMAPPED_DATA;
            end
        end
    end

    // Freezing waits for the field boundary so a field is never cut short.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            frz_r <= GIC_FRZ_RUN;
        end else begin
            case (frz_r)
                GIC_FRZ_RUN: begin
                    if (genlock_r[`GIC_BIT_FREEZE]) frz_r <= GIC_FRZ_PEND;
                end
                GIC_FRZ_PEND: begin
                    if (!genlock_r[`GIC_BIT_FREEZE]) frz_r <= GIC_FRZ_RUN;
                    else if (field_end_i) frz_r <= GIC_FRZ_HOLD;
                end
                GIC_FRZ_HOLD: begin
                    if (!genlock_r[`GIC_BIT_FREEZE]) frz_r <= GIC_FRZ_RESUME;
                end
                GIC_FRZ_RESUME: begin
                    if (genlock_r[`GIC_BIT_FREEZE]) frz_r <= GIC_FRZ_HOLD;
                    else if (field_start_i) frz_r <= GIC_FRZ_RUN;
                end
                default: frz_r <= GIC_FRZ_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pclk_meta_r <= 1'b0;
            pclk_sync_r <= 1'b0;
        end else begin
            pclk_meta_r <= pixel_clock_in_i;
            pclk_sync_r <= pclk_meta_r;
        end
    end

    // The clock AND uses the sampled clock, so its edges lag the pin by two cycles.
    always_comb begin
        strobe_nxt = 1'b0;
        if (wide_fmt) begin
            strobe_nxt = genlock_r[`GIC_BIT_LINE_TIME] | (active_video_i & active_line_i);
            strobe_nxt = strobe_nxt & (genlock_r[`GIC_BIT_DUTY] ? line_lock_i
                                                              : pixel_phase_i);
        end else if (narrow_fmt) begin
            strobe_nxt = normal_strobe_i & (~genlock_r[`GIC_BIT_LINE_TIME] | pclk_sync_r);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pixel_valid_strobe_o <= 1'b0;
            timing_frozen_o      <= 1'b0;
            square_pixel_o       <= 1'b0;
            clock_freq_o         <= 2'h1;
            aa_bypass_o          <= 1'b0;
            source_sel_o         <= 2'h0;
        end else begin
            pixel_valid_strobe_o <= strobe_nxt;
            timing_frozen_o      <= frz_r == GIC_FRZ_HOLD || frz_r == GIC_FRZ_RESUME;
            square_pixel_o       <= genlock_r[`GIC_BIT_ASPECT];
            clock_freq_o         <= genlock_r[`GIC_CLKF_MSB:`GIC_CLKF_LSB];
            aa_bypass_o          <= analog_r[`GIC_BIT_AA_BYPASS];
            if (!analog_r[`GIC_SRC_MSB]) begin
                source_sel_o <= analog_r[1:0];
            end
        end
    end

    gic_miss_cnt #(.LONG_CNT(H_MISS_LONG), .CNT_W(`GIC_MISS_CNT_W)) u_hmiss (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .expect_i  (hsync_expect_i),
        .seen_i    (hsync_seen_i),
        .single_i  (genlock_r[`GIC_BIT_HMISS_SEL]),
        .acquire_o (h_acquire_o)
    );

    gic_miss_cnt #(.LONG_CNT(V_MISS_LONG), .CNT_W(`GIC_MISS_CNT_W)) u_vmiss (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .expect_i  (vsync_expect_i),
        .seen_i    (vsync_seen_i),
        .single_i  (genlock_r[`GIC_BIT_VMISS_SEL]),
        .acquire_o (v_acquire_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_aspect;
        ##1 square_pixel_o == $past(genlock_r[`GIC_BIT_ASPECT]);
    endproperty
    a_aspect: assert property (p_aspect) else $error("aspect output wrong");

    property p_freeze_start;
        $rose(timing_frozen_o) |-> $past(field_end_i, 2);
    endproperty
    a_freeze_start: assert property (p_freeze_start) else $error("freeze not at end");

    property p_freeze_resume;
        $fell(timing_frozen_o) |-> $past(field_start_i, 2);
    endproperty
    a_freeze_resume: assert property (p_freeze_resume) else $error("resume not at start");

    property p_wide_inactive;
        wide_fmt && !genlock_r[`GIC_BIT_LINE_TIME] && !(active_video_i && active_line_i)
        |=> !pixel_valid_strobe_o;
    endproperty
    a_wide_inactive: assert property (p_wide_inactive) else $error("strobe not active");

    property p_wide_duty;
        wide_fmt && !genlock_r[`GIC_BIT_DUTY] && genlock_r[`GIC_BIT_LINE_TIME]
        |=> pixel_valid_strobe_o == $past(pixel_phase_i);
    endproperty
    a_wide_duty: assert property (p_wide_duty) else $error("strobe not at pixel rate");

    property p_narrow_normal;
        narrow_fmt && !genlock_r[`GIC_BIT_LINE_TIME]
        |=> pixel_valid_strobe_o == $past(normal_strobe_i);
    endproperty
    a_narrow_normal: assert property (p_narrow_normal) else $error("8-bit strobe wrong");

    property p_llg_auto;
        sync_loss_i && gain_fld != GIC_GAIN_AUTO && llg_fld == GIC_LLG_AUTO
        |=> gain_fld == GIC_GAIN_AUTO ##1 gain_mode_o == GIC_GAIN_AUTO;
    endproperty
    a_llg_auto: assert property (p_llg_auto) else $error("gain not rewritten");

    property p_llg_keep;
        sync_loss_i && llg_fld == GIC_LLG_KEEP && !wr_en_i |=> $stable(gain_fld);
    endproperty
    a_llg_keep: assert property (p_llg_keep) else $error("gain field changed");

    property p_aa;
        ##1 aa_bypass_o == $past(analog_r[`GIC_BIT_AA_BYPASS]);
    endproperty
    a_aa: assert property (p_aa) else $error("anti-alias output wrong");

    cover property (sync_loss_i && llg_fld == GIC_LLG_RELOCK ##[1:50] lock_achieved_i);
    cover property ($rose(timing_frozen_o) ##[1:100] $fell(timing_frozen_o));
    cover property (narrow_fmt && genlock_r[`GIC_BIT_LINE_TIME] && pixel_valid_strobe_o);
endmodule // gic_regs

// file: gic_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the genlock and input registers.
// Assumes: Byte-wide registers reached by sub address.
// Notes:   Definitions only.
`ifndef GIC_CFG_SVH
`define GIC_CFG_SVH

`define GIC_ADDR_GENLOCK   8'h04
`define GIC_ADDR_ANALOG    8'h05
`define GIC_GENLOCK_RST    8'h09
`define GIC_ANALOG_RST     8'h10
`define GIC_UNMAPPED_DATA  8'h00

`define GIC_BIT_ASPECT     7
`define GIC_BIT_FREEZE     6
`define GIC_BIT_DUTY       5
`define GIC_BIT_LINE_TIME  4
`define GIC_BIT_HMISS_SEL  3
`define GIC_BIT_VMISS_SEL  2
`define GIC_CLKF_MSB       1
`define GIC_CLKF_LSB       0

`define GIC_LLG_MSB        7
`define GIC_LLG_LSB        6
`define GIC_GAIN_MSB       5
`define GIC_GAIN_LSB       4
`define GIC_BIT_AA_BYPASS  3
`define GIC_SRC_MSB        2
`define GIC_SRC_LSB        0

`define GIC_H_MISS_LONG    12
`define GIC_V_MISS_LONG    3
`define GIC_MISS_CNT_W     8

`endif

// file: gic_pkg.sv
// Purpose: Types shared by the genlock and input control logic.
// Assumes: Codes match the register fields.
// Notes:   Reserved codes are listed so decoders can name them.
package gic_pkg;

    typedef enum logic [2:0] {
        GIC_FMT_YC16  = 3'h0,
        GIC_FMT_YC8   = 3'h1,
        GIC_FMT_EMB8  = 3'h2,
        GIC_FMT_RGB15 = 3'h3,
        GIC_FMT_RGB16 = 3'h4
    } gic_fmt_t;

    typedef enum logic [1:0] {
        GIC_GAIN_UNITY  = 2'h0,
        GIC_GAIN_AUTO   = 2'h1,
        GIC_GAIN_FIXED  = 2'h2,
        GIC_GAIN_FREEZE = 2'h3
    } gic_gain_t;

    typedef enum logic [1:0] {
        GIC_LLG_AUTO   = 2'h0,
        GIC_LLG_KEEP   = 2'h1,
        GIC_LLG_RELOCK = 2'h2,
        GIC_LLG_RSVD   = 2'h3
    } gic_llg_t;

    typedef enum logic [1:0] {
        GIC_FRZ_RUN,
        GIC_FRZ_PEND,
        GIC_FRZ_HOLD,
        GIC_FRZ_RESUME
    } gic_frz_state_t;

endpackage

// file: gic_miss_cnt.sv
// Purpose: Counts consecutive missing sync pulses and requests lock acquisition.
// Assumes: expect_i marks each slot where a sync pulse is due, same clock.
// Notes:   The count restarts after each request so a long outage requests repeatedly.
`timescale 1ns/1ps
`include "gic_cfg.svh"
module gic_miss_cnt #(
    parameter int LONG_CNT = `GIC_H_MISS_LONG,
    parameter int CNT_W    = `GIC_MISS_CNT_W
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic expect_i,
    input  wire logic seen_i,
    input  wire logic single_i,
    output logic      acquire_o
);
    logic [CNT_W-1:0] miss_r;
    logic [CNT_W-1:0] limit;

    if (LONG_CNT < 1 || LONG_CNT >= (1 << CNT_W)) begin : g_chk
        $error("LONG_CNT does not fit the counter");
    end

    assign limit = single_i ? CNT_W'(1) : CNT_W'(LONG_CNT);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            miss_r    <= '0;
            acquire_o <= 1'b0;
        end else begin
            acquire_o <= 1'b0;
            if (expect_i) begin
                if (seen_i) begin
                    miss_r <= '0;
                end else if (miss_r + CNT_W'(1) >= limit) begin
                    miss_r    <= '0;
                    acquire_o <= 1'b1;
                end else begin
                    miss_r <= miss_r + CNT_W'(1);
                end
            end
        end
    end

    property p_acquire_cause;
        @(posedge clk_i) disable iff (rst_i)
        acquire_o |-> $past(expect_i) && !$past(seen_i);
    endproperty
    a_acquire_cause: assert property (p_acquire_cause) else $error("acquire without a miss");

    property p_single_miss;
        @(posedge clk_i) disable iff (rst_i)
        expect_i && !seen_i && single_i |=> acquire_o;
    endproperty
    a_single_miss: assert property (p_single_miss) else $error("single miss did not acquire");

    cover property (@(posedge clk_i) disable iff (rst_i) acquire_o && !$past(single_i));
endmodule // gic_miss_cnt

// file: gic_host.sv
// Purpose: Host model that reaches the control registers by sub address.
// Assumes: Write and read strobes are one-cycle pulses on the register clock.
// Notes:   Released bus lines show the inverse of the last value, never a stale copy.
`timescale 1ns/1ps
module gic_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic      [7:0] wdata_o
);
    initial begin
        addr_o  = 8'h00;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        wdata_o = 8'h00;
    end

    // Callers program clock codes freely; none is checked against a supplied pixel clock.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_en_o <= 1'b1;
        @(posedge clk_i);
        addr_o  <= ~a;
        wdata_o <= ~d;
        wr_en_o <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        rd_en_o <= 1'b1;
        @(posedge clk_i);
        addr_o  <= ~a;
        rd_en_o <= 1'b0;
        #1 d = rdata_i;
    endtask
endmodule // gic_host

// file: gic_regs_tb.sv
// Purpose: Self-checking bench for the genlock and input control registers.
// Assumes: Timing events are driven here in place of the timing core.
// Notes:   Rows hold {addr, data, format, levels, outputs, strobe}.
`timescale 1ns/1ps
module gic_regs_tb;
    import gic_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] fmt = 3'h0;
    logic [5:0] lv = 6'h00;
    logic [5:0] evt = 6'h00;
    logic       hs = 1'b0;
    logic       vs = 1'b0;
    logic [7:0] addr, wdata, rdata, outs, d, e;
    logic       wr_en, rd_en, sq, frz, strobe, h_acq, v_acq, aa;
    logic [1:0] clkf, gain, src;
    logic [33:0] r;
    int         fails = 0;
    int         num_checks = 0;
    int         h_cnt = 0;
    int         v_cnt = 0;
    logic [33:0] rows [0:17] = '{
        {8'h04, 8'h80, 3'h0, 6'h38, 8'h84, 1'h1}, {8'h04, 8'h82, 3'h0, 6'h18, 8'hA4, 1'h0},
        {8'h04, 8'h12, 3'h3, 6'h08, 8'h24, 1'h1}, {8'h04, 8'h32, 3'h4, 6'h08, 8'h24, 1'h0},
        {8'h04, 8'h32, 3'h4, 6'h04, 8'h24, 1'h1}, {8'h04, 8'h12, 3'h1, 6'h03, 8'h24, 1'h1},
        {8'h04, 8'h12, 3'h1, 6'h02, 8'h24, 1'h0}, {8'h04, 8'h02, 3'h2, 6'h02, 8'h24, 1'h1},
        {8'h04, 8'h09, 3'h5, 6'h3A, 8'h14, 1'h0}, {8'h05, 8'h18, 3'h0, 6'h38, 8'h54, 1'h1},
        {8'h05, 8'h11, 3'h0, 6'h38, 8'h15, 1'h1}, {8'h05, 8'h12, 3'h0, 6'h38, 8'h16, 1'h1},
        {8'h05, 8'h13, 3'h0, 6'h38, 8'h17, 1'h1}, {8'h05, 8'h14, 3'h0, 6'h38, 8'h17, 1'h1},
        {8'h05, 8'h00, 3'h0, 6'h38, 8'h10, 1'h1}, {8'h05, 8'h20, 3'h0, 6'h38, 8'h18, 1'h1},
        {8'h05, 8'h30, 3'h0, 6'h38, 8'h1C, 1'h1}, {8'h07, 8'hFF, 3'h0, 6'h38, 8'h1C, 1'h1}};

    assign outs = {sq, aa, clkf, gain, src};

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (h_acq === 1'b1) h_cnt++;
        if (v_acq === 1'b1) v_cnt++;
    end

    gic_host i_gic_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_en_o(wr_en),
        .rd_en_o(rd_en), .wdata_o(wdata));

    gic_regs i_gic_regs (.clk_i(clk_i), .rst_i(rst), .addr_i(addr), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata), .out_format_i(fmt),
        .field_end_i(evt[0]), .field_start_i(evt[1]), .active_video_i(lv[5]),
        .active_line_i(lv[4]), .pixel_phase_i(lv[3]), .line_lock_i(lv[2]),
        .normal_strobe_i(lv[1]), .pixel_clock_in_i(lv[0]), .hsync_expect_i(evt[4]),
        .hsync_seen_i(hs), .vsync_expect_i(evt[5]), .vsync_seen_i(vs),
        .sync_loss_i(evt[2]), .lock_achieved_i(evt[3]), .square_pixel_o(sq),
        .timing_frozen_o(frz), .pixel_valid_strobe_o(strobe), .h_acquire_o(h_acq),
        .v_acquire_o(v_acq), .clock_freq_o(clkf), .gain_mode_o(gain), .aa_bypass_o(aa),
        .source_sel_o(src));

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
        num_checks++;
        if (g !== ex) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic test_done;
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One-cycle pulse on one timing event line.
    task automatic ev(input int k);
        @(posedge clk_i);
        evt[k] <= 1'b1;
        @(posedge clk_i);
        evt <= 6'h00;
    endtask

    task automatic miss(input int k, input int n);
        repeat (n) ev(k);
        repeat (4) @(posedge clk_i);
        #1 chk("acq_idle", 8'h00, {6'h00, v_acq, h_acq});
    endtask

    task automatic chk_rst;
        i_gic_host.rd(8'h04, d);
        chk("rst_genlock", 8'h09, d);
        i_gic_host.rd(8'h05, d);
        chk("rst_analog", 8'h10, d);
        chk("rst_outs", 8'h14, outs);
    endtask

    // Writes the analog register, raises sync loss and checks field and mode.
    task automatic gl(input logic [7:0] wv, input logic [7:0] er, input logic [7:0] em);
        i_gic_host.wr(8'h05, wv);
        ev(2);
        repeat (3) @(posedge clk_i);
        i_gic_host.rd(8'h05, d);
        chk("gain_field", er, d);
        chk("gain_mode", em, {6'h00, gain});
    endtask

    task automatic frz_at(input logic [7:0] ex);
        @(posedge clk_i);
        #1 chk("frozen", ex, {7'h00, frz});
    endtask

    initial begin
        #200000;
        fails++;
        test_done;
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst <= 1'b0;
        chk_rst;
        chk("strobe", 8'h00, {7'h00, strobe});
        for (int i = 0; i < 18; i++) begin
            r = rows[i];
            @(posedge clk_i);
            fmt <= r[17:15];
            lv  <= r[14:9];
            i_gic_host.wr(r[33:26], r[25:18]);
            i_gic_host.rd(r[33:26], d);
            e = (r[33:26] == 8'h04 || r[33:26] == 8'h05) ? r[25:18] : 8'h00;
            chk("rdata", e, d);
            repeat (4) @(posedge clk_i);
            #1 chk("outs", r[8:1], outs);
            chk("strobe", {7'h00, r[0]}, {7'h00, strobe});
        end
        i_gic_host.wr(8'h04, 8'h49);
        repeat (4) @(posedge clk_i);
        frz_at(8'h00);
        ev(0);
        #1 chk("frozen", 8'h00, {7'h00, frz});
        frz_at(8'h01);
        i_gic_host.wr(8'h04, 8'h09);
        repeat (4) @(posedge clk_i);
        ev(1);
        #1 chk("frozen", 8'h01, {7'h00, frz});
        frz_at(8'h00);
        i_gic_host.wr(8'h04, 8'h49);
        i_gic_host.wr(8'h04, 8'h09);
        ev(0);
        repeat (4) @(posedge clk_i);
        frz_at(8'h00);
        miss(4, 1);
        chk("h_cnt", 8'h01, 8'(h_cnt));
        miss(5, 2);
        chk("v_cnt", 8'h00, 8'(v_cnt));
        miss(5, 1);
        chk("v_cnt", 8'h01, 8'(v_cnt));
        i_gic_host.wr(8'h04, 8'h01);
        miss(4, 11);
        @(posedge clk_i);
        hs <= 1'b1;
        ev(4);
        hs <= 1'b0;
        miss(4, 11);
        chk("h_cnt", 8'h01, 8'(h_cnt));
        miss(4, 1);
        chk("h_cnt", 8'h02, 8'(h_cnt));
        i_gic_host.wr(8'h04, 8'h05);
        miss(5, 1);
        chk("v_cnt", 8'h02, 8'(v_cnt));
        gl(8'h30, 8'h10, 8'h01);
        gl(8'h10, 8'h10, 8'h01);
        gl(8'h60, 8'h60, 8'h02);
        gl(8'hB0, 8'h90, 8'h01);
        gl(8'hA0, 8'hA0, 8'h01);
        ev(3);
        repeat (3) @(posedge clk_i);
        #1 chk("gain_mode", 8'h02, {6'h00, gain});
        // Freeze gain under code 00, so the loss below must rewrite over the host write.
        i_gic_host.wr(8'h05, 8'h30);
        fork
            i_gic_host.wr(8'h05, 8'h00);
            ev(2);
        join
        repeat (3) @(posedge clk_i);
        i_gic_host.rd(8'h05, d);
        chk("gain_field", 8'h10, d);
        @(posedge clk_i);
        rst <= 1'b1;
        #1 chk("rst_outs", 8'h14, outs);
        repeat (3) @(posedge clk_i);
        rst <= 1'b0;
        chk_rst;
        test_done;
    end
endmodule // gic_regs_tb
